// ---- logic/usy_sync_port.sv ----
// clocked half-duplex serial port with apb register access
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - master needs clocked and master bits; enable gates
// - no receive enable means transmitter
// - no framing bits, never send and receive together
// - master drives clock pin, driver enabled automatically
// - one clock per bit, change lead, valid trail
// - polarity sets idle level and change edge
// - master transmit drives data and clock pins
// - holding write starts send, waits for shifter
// - ninth transmit bit from its register field
// - master receive releases data pin driver
// - single receive: one character, then hardware clears
// - continuous clocks; clearing mid-character aborts, discards
// - both set: clear single, continue continuously
// - sample data pin on trailing clock edge
// - characters enter two-entry fifo, flag while unread
// - slave takes clock from pin, driver off
// - third character sets overrun, fifo kept
// - overrun clear by read or continuous clear
// - nine-bit receive; ninth bit of oldest entry
// - master rate from sixteen-bit divisor pair
module usy_sync_port
	import usy_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [USY_ADDR_W-1:0] paddr,
	input wire logic [USY_DATA_W-1:0] pwdata,
	output logic [USY_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clock_transmit_pin_sense,
	output logic clock_transmit_pin_value,
	output logic clock_transmit_pin_oe,
	input wire logic data_receive_pin_sense,
	output logic data_receive_pin_value,
	output logic data_receive_pin_oe
);

	// ==========================================================
	// address decode shared by error answer and write gating
	function automatic logic addr_mapped(input logic [USY_ADDR_W-1:0] a);
		return (a == USY_OFF_TSC) || (a == USY_OFF_RSC) || (a == USY_OFF_BCN) ||
			(a == USY_OFF_BDL) || (a == USY_OFF_BDH) || (a == USY_OFF_THR) ||
			(a == USY_OFF_RDR) || (a == USY_OFF_FLG);
	endfunction

	// ==========================================================
	// register group state
	logic [7:0] tsc_reg, tsc_next; // transmit_status_control
	logic [7:0] rsc_reg, rsc_next; // receive_status_control, control half
	logic [7:0] bcn_reg, bcn_next; // baud_control
	logic [7:0] bdl_reg, bdl_next; // baud_divisor_low
	logic [7:0] bdh_reg, bdh_next; // baud_divisor_high
	logic [8:0] thr_reg, thr_next; // transmit_holding with ninth bit
	logic thr_full_reg, thr_full_next; // holding register occupied
	logic [USY_DATA_W-1:0] prdata_reg, prdata_next; // read answer
	logic pready_reg, pready_next; // one wait state then ready
	logic [7:0] rd_byte; // read mux output

	// link group state
	usy_link_e state_reg, state_next; // sequencer
	logic [8:0] tsr_reg, tsr_next; // transmit_shifter
	logic [8:0] rsr_reg, rsr_next; // receive_shifter
	logic [3:0] bitcnt_reg, bitcnt_next; // bits done in this character
	logic sclk_reg, sclk_next; // master clock, 1 = active level
	logic dto_reg, dto_next; // data pin output bit
	logic ckp_reg, ckp_next; // previous active level of clock pin
	logic [8:0] fifo_reg [2]; // receive fifo storage
	logic [8:0] fifo_next [2];
	logic fifo_rd_reg, fifo_rd_next; // oldest entry index
	logic [1:0] fifo_cnt_reg, fifo_cnt_next; // unread entries
	logic ovr_reg, ovr_next; // overrun_flag
	logic ovr_single_reg, ovr_single_next; // overrun arose in single mode

	// ==========================================================
	// mode decode
	logic port_on; // port enabled in clocked mode
	logic master; // master role
	logic rx_mode; // any receive enable set
	logic tx_mode; // transmitter role
	logic pol; // clock idle level
	logic [3:0] tx_bits; // bits per transmitted character
	logic [3:0] rx_bits; // bits per received character
	logic tick; // baud tick
	logic ck_act; // clock pin seen as active level
	logic lead; // leading clock edge event
	logic trail; // trailing clock edge event
	logic [8:0] rx_shift; // receive shifter after this sample
	logic [8:0] rx_char; // received character, right aligned
	logic [8:0] head; // oldest fifo entry
	logic thr_take; // holding register moved to shifter
	logic single_done; // single receive finished a character
	logic rx_done; // character complete on the receiver
	logic reg_access, rd_latch, reg_write, rd_pop; // apb phase decodes

	assign port_on = rsc_reg[USY_RSC_PORT_EN] && tsc_reg[USY_TSC_CLOCKED];
	assign master = port_on && tsc_reg[USY_TSC_MASTER];
	assign rx_mode = rsc_reg[USY_RSC_SINGLE] || rsc_reg[USY_RSC_CONT];
	assign tx_mode = !rx_mode;
	assign pol = bcn_reg[USY_BCN_POL];
	assign tx_bits = tsc_reg[USY_TSC_NINE] ? USY_BITS_WIDE : USY_BITS_NARROW;
	assign rx_bits = rsc_reg[USY_RSC_NINE] ? USY_BITS_WIDE : USY_BITS_NARROW;
	assign head = fifo_reg[fifo_rd_reg];

	// ==========================================================
	// master rate generator
	usy_baud_gen #(
		.DIV_W(16)
	) u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.run(master && (state_reg != LK_IDLE)),
		.wide(bcn_reg[USY_BCN_WIDE]),
		.divisor({bdh_reg, bdl_reg}),
		.tick(tick)
	);

	// ==========================================================
	// clock edge events: baud ticks as master, pin edges as slave
	// the pin is taken as synchronous, so one stored level finds its edges
	assign ck_act = clock_transmit_pin_sense ^ pol;
	assign lead = master ? (tick && !sclk_reg) : (ck_act && !ckp_reg);
	assign trail = master ? (tick && sclk_reg) : (!ck_act && ckp_reg);

	// bits enter at the top, so the first bit ends lowest, ninth last
	assign rx_shift = {data_receive_pin_sense, rsr_reg[8:1]};
	assign rx_char = (rx_bits == USY_BITS_WIDE) ? rx_shift : {1'b0, rx_shift[8:1]};

	// ==========================================================
	// pins: clock driven only as master, data only in transmit mode
	assign clock_transmit_pin_oe = master;
	assign clock_transmit_pin_value = sclk_reg ^ pol;
	assign data_receive_pin_oe = port_on && tx_mode && (state_reg != LK_RX) &&
		(master || tsc_reg[USY_TSC_TRANSMITTER_ENABLE]);
	assign data_receive_pin_value = dto_reg;

	// ==========================================================
	// apb phases: read data is latched in the first cycle, writes land with ready in the second
	assign reg_access = psel && penable;
	assign rd_latch = reg_access && !pready_reg && !pwrite;
	assign reg_write = reg_access && pready_reg && pwrite && addr_mapped(paddr);
	assign rd_pop = rd_latch && (paddr == USY_OFF_RDR) && (fifo_cnt_reg != 2'h0);
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pready_reg && !addr_mapped(paddr);

	// read mux; status bits come straight from the link state and the holding flag
	always_comb
	begin
		case (paddr)
			USY_OFF_TSC: rd_byte = {tsc_reg[7:2], state_reg != LK_TX, tsc_reg[0]};
			USY_OFF_RSC: rd_byte = {rsc_reg[7:4], 2'h0, ovr_reg,
				(fifo_cnt_reg != 2'h0) && head[8]};
			USY_OFF_BCN: rd_byte = bcn_reg;
			USY_OFF_BDL: rd_byte = bdl_reg;
			USY_OFF_BDH: rd_byte = bdh_reg;
			USY_OFF_RDR: rd_byte = (fifo_cnt_reg != 2'h0) ? head[7:0] : 8'h00;
			USY_OFF_FLG: rd_byte = {6'h00, fifo_cnt_reg != 2'h0, !thr_full_reg};
			default: rd_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// register group next values
	always_comb
	begin
		tsc_next = tsc_reg;
		rsc_next = rsc_reg;
		bcn_next = bcn_reg;
		bdl_next = bdl_reg;
		bdh_next = bdh_reg;
		thr_next = thr_reg;
		thr_full_next = thr_full_reg;
		prdata_next = prdata_reg;
		pready_next = reg_access && !pready_reg;
		// hardware actions first, so a software write in the same cycle wins
		if (thr_take)
			thr_full_next = 1'b0;
		if (single_done)
			rsc_next[USY_RSC_SINGLE] = 1'b0;
		if (reg_write)
		begin
			case (paddr)
				USY_OFF_TSC: tsc_next = pwdata[7:0] & USY_TSC_WMASK;
				USY_OFF_RSC: rsc_next = pwdata[7:0] & USY_RSC_WMASK;
				USY_OFF_BCN: bcn_next = pwdata[7:0] & USY_BCN_WMASK;
				USY_OFF_BDL: bdl_next = pwdata[7:0];
				USY_OFF_BDH: bdh_next = pwdata[7:0];
				USY_OFF_THR:
				begin
					// ninth bit captured with the byte; a write while full overwrites
					thr_next = {tsc_reg[USY_TSC_NINE] && tsc_reg[USY_TSC_NINTH],
						pwdata[7:0]};
					thr_full_next = 1'b1;
				end
				default: thr_full_next = thr_full_next;
			endcase
		end
		if (rd_latch)
			prdata_next = {{(USY_DATA_W-8){1'b0}}, rd_byte};
	end

	// register only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tsc_reg <= USY_RST_CTRL;
			rsc_reg <= USY_RST_CTRL;
			bcn_reg <= USY_RST_CTRL;
			bdl_reg <= USY_RST_CTRL;
			bdh_reg <= USY_RST_CTRL;
			thr_reg <= '0;
			thr_full_reg <= 1'b0;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
		end
		else
		begin
			tsc_reg <= tsc_next;
			rsc_reg <= rsc_next;
			bcn_reg <= bcn_next;
			bdl_reg <= bdl_next;
			bdh_reg <= bdh_next;
			thr_reg <= thr_next;
			thr_full_reg <= thr_full_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
		end
	end

	// ==========================================================
	// link group next values: sequencer, shifters, fifo, overrun
	always_comb
	begin
		state_next = state_reg;
		tsr_next = tsr_reg;
		rsr_next = rsr_reg;
		bitcnt_next = bitcnt_reg;
		sclk_next = sclk_reg;
		dto_next = dto_reg;
		ckp_next = ck_act;
		fifo_next = fifo_reg;
		fifo_rd_next = fifo_rd_reg;
		fifo_cnt_next = fifo_cnt_reg;
		ovr_next = ovr_reg;
		ovr_single_next = ovr_single_reg;
		thr_take = 1'b0;
		single_done = 1'b0;
		rx_done = 1'b0;
		// a read hands the oldest entry to software
		if (rd_pop)
		begin
			fifo_rd_next = !fifo_rd_reg;
			fifo_cnt_next = fifo_cnt_reg - 2'h1;
		end
		// overrun release depends on the mode it arose in
		if (ovr_single_reg ? rd_pop : !rsc_reg[USY_RSC_CONT])
			ovr_next = 1'b0;
		unique case (state_reg)
			LK_IDLE:
			begin
				sclk_next = 1'b0;
				bitcnt_next = 4'h0;
				if (tx_mode && tsc_reg[USY_TSC_TRANSMITTER_ENABLE] && thr_full_reg)
				begin
					tsr_next = thr_reg;
					thr_take = 1'b1;
					state_next = LK_TX;
				end
				else if (rx_mode && !(master && ovr_reg))
				begin
					rsr_next = '0;
					state_next = LK_RX;
				end
			end
			LK_TX:
			begin
				if (!tx_mode || !tsc_reg[USY_TSC_TRANSMITTER_ENABLE])
				begin
					// transmitter dropped: stop at once, idle clock level
					sclk_next = 1'b0;
					state_next = LK_IDLE;
				end
				else if (lead)
				begin
					dto_next = tsr_reg[0];
					tsr_next = {1'b0, tsr_reg[8:1]};
					sclk_next = 1'b1;
				end
				else if (trail)
				begin
					sclk_next = 1'b0;
					bitcnt_next = bitcnt_reg + 4'h1;
					if (bitcnt_reg + 4'h1 == tx_bits)
					begin
						// last bit out: a waiting character follows with no gap
						bitcnt_next = 4'h0;
						if (thr_full_reg)
						begin
							tsr_next = thr_reg;
							thr_take = 1'b1;
						end
						else
							state_next = LK_IDLE;
					end
				end
			end
			LK_RX:
			begin
				if (!rx_mode || (master && ovr_reg))
				begin
					// partial character thrown away, clock stops
					sclk_next = 1'b0;
					bitcnt_next = 4'h0;
					state_next = LK_IDLE;
				end
				else if (lead)
					sclk_next = 1'b1;
				else if (trail)
				begin
					sclk_next = 1'b0;
					rsr_next = rx_shift;
					bitcnt_next = bitcnt_reg + 4'h1;
					if (bitcnt_reg + 4'h1 == rx_bits)
					begin
						bitcnt_next = 4'h0;
						rx_done = 1'b1;
						if (ovr_reg)
							ovr_next = 1'b1;
						else if (fifo_cnt_next == USY_FIFO_DEPTH)
						begin
							// contents kept; set wins over any release above
							ovr_next = 1'b1;
							ovr_single_next = rsc_reg[USY_RSC_SINGLE] &&
								!rsc_reg[USY_RSC_CONT];
						end
						else
						begin
							fifo_next[fifo_rd_next ^ fifo_cnt_next[0]] = rx_char;
							fifo_cnt_next = fifo_cnt_next + 2'h1;
						end
						if (master && rsc_reg[USY_RSC_SINGLE])
							single_done = 1'b1;
						// pause so the cleared single bit is seen before more clocks
						if (master && !rsc_reg[USY_RSC_CONT])
							state_next = LK_IDLE;
					end
				end
			end
		endcase
		// port disabled acts as a module reset of the link side
		if (!port_on)
		begin
			state_next = LK_IDLE;
			sclk_next = 1'b0;
			dto_next = 1'b0;
			bitcnt_next = 4'h0;
			fifo_rd_next = 1'b0;
			fifo_cnt_next = 2'h0;
			ovr_next = 1'b0;
			ovr_single_next = 1'b0;
		end
	end

	// register only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= LK_IDLE;
			tsr_reg <= '0;
			rsr_reg <= '0;
			bitcnt_reg <= 4'h0;
			sclk_reg <= 1'b0;
			dto_reg <= 1'b0;
			ckp_reg <= 1'b0;
			fifo_reg <= '{default: '0};
			fifo_rd_reg <= 1'b0;
			fifo_cnt_reg <= 2'h0;
			ovr_reg <= 1'b0;
			ovr_single_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			tsr_reg <= tsr_next;
			rsr_reg <= rsr_next;
			bitcnt_reg <= bitcnt_next;
			sclk_reg <= sclk_next;
			dto_reg <= dto_next;
			ckp_reg <= ckp_next;
			fifo_reg <= fifo_next;
			fifo_rd_reg <= fifo_rd_next;
			fifo_cnt_reg <= fifo_cnt_next;
			ovr_reg <= ovr_next;
			ovr_single_reg <= ovr_single_next;
		end
	end

	// ==========================================================
	// checks on the link behaviour
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_half_duplex: assert property (state_reg == LK_RX || rx_mode |-> !data_receive_pin_oe)
		else $error("data pin driven while receiving");
	a_idle_level: assert property (master && state_reg == LK_IDLE |=>
		clock_transmit_pin_value == pol || state_reg != LK_IDLE)
		else $error("master clock not at idle level");
	a_tx_drivers: assert property (master && tx_mode && state_reg != LK_RX |->
		data_receive_pin_oe && clock_transmit_pin_oe)
		else $error("transmit drivers not enabled");
	a_fifo_bound: assert property (fifo_cnt_reg <= USY_FIFO_DEPTH)
		else $error("fifo count beyond depth");
	a_ovr_cause: assert property ($rose(ovr_reg) |-> $past(fifo_cnt_reg) == USY_FIFO_DEPTH)
		else $error("overrun without full fifo");
	a_ovr_keep: assert property (rx_done && fifo_cnt_reg == USY_FIFO_DEPTH && !rd_pop
		&& port_on |=> fifo_cnt_reg == USY_FIFO_DEPTH && ovr_reg)
		else $error("full fifo changed on overrun");
	a_single_clear: assert property (rx_done && master && rsc_reg[USY_RSC_SINGLE]
		&& !reg_write |=> !rsc_reg[USY_RSC_SINGLE])
		else $error("single receive not cleared");
	a_abort_stop: assert property (state_reg == LK_RX && !rx_mode |=>
		state_reg == LK_IDLE && !sclk_reg ##1 bitcnt_reg == 4'h0)
		else $error("receive abort did not stop clock");
	a_tx_start: assert property (state_reg == LK_IDLE && port_on && tx_mode &&
		tsc_reg[USY_TSC_TRANSMITTER_ENABLE] && thr_full_reg |=> state_reg == LK_TX)
		else $error("holding data not moved to shifter");

endmodule

`default_nettype wire

// ---- logic/usy_pkg.sv ----
// package: register map, field positions and link states of the clocked serial port
package usy_pkg;

	// ==========================================================
	// bus geometry
	localparam int USY_ADDR_W = 8; // byte address bits decoded
	localparam int USY_DATA_W = 32; // apb data width

	// ==========================================================
	// register byte offsets, one aligned word each
	localparam logic [7:0] USY_OFF_TSC = 8'h00; // transmit_status_control
	localparam logic [7:0] USY_OFF_RSC = 8'h04; // receive_status_control
	localparam logic [7:0] USY_OFF_BCN = 8'h08; // baud_control
	localparam logic [7:0] USY_OFF_BDL = 8'h0c; // baud_divisor_low
	localparam logic [7:0] USY_OFF_BDH = 8'h10; // baud_divisor_high
	localparam logic [7:0] USY_OFF_THR = 8'h14; // transmit_holding, write only
	localparam logic [7:0] USY_OFF_RDR = 8'h18; // receive_data_register, read pops
	localparam logic [7:0] USY_OFF_FLG = 8'h1c; // event flags, read only

	// ==========================================================
	// transmit_status_control fields
	localparam int USY_TSC_MASTER = 7; // clock_source_master_select
	localparam int USY_TSC_NINE = 6; // nine_bit_transmit_enable
	localparam int USY_TSC_TRANSMITTER_ENABLE = 5; // transmitter_enable
	localparam int USY_TSC_CLOCKED = 4; // clocked-mode select
	localparam int USY_TSC_HISPEED = 2; // high_speed_divisor_select
	localparam int USY_TSC_SHEMPTY = 1; // shifter idle, read only
	localparam int USY_TSC_NINTH = 0; // transmit_ninth_bit
	localparam logic [7:0] USY_TSC_WMASK = 8'hf5; // writable bits

	// receive_status_control fields
	localparam int USY_RSC_PORT_EN = 7; // serial_port_enable
	localparam int USY_RSC_NINE = 6; // nine_bit_receive_enable
	localparam int USY_RSC_SINGLE = 5; // single_receive_enable
	localparam int USY_RSC_CONT = 4; // continuous_receive_enable
	localparam int USY_RSC_OVERRUN = 1; // overrun_flag, read only
	localparam int USY_RSC_NINTH = 0; // receive_ninth_bit, read only
	localparam logic [7:0] USY_RSC_WMASK = 8'hf0; // writable bits

	// baud_control fields
	localparam int USY_BCN_POL = 4; // clock_idle_polarity
	localparam int USY_BCN_WIDE = 3; // wide_divisor_select
	localparam logic [7:0] USY_BCN_WMASK = 8'h18; // writable bits

	// flag word fields
	localparam int USY_FLG_TXEMPTY = 0; // transmit_empty_flag
	localparam int USY_FLG_RXFULL = 1; // receive_interrupt_flag

	// ==========================================================
	// reset values and character geometry
	localparam logic [7:0] USY_RST_CTRL = 8'h00; // all control bytes
	localparam logic [3:0] USY_BITS_NARROW = 4'h8; // bits per 8-bit character
	localparam logic [3:0] USY_BITS_WIDE = 4'h9; // bits per 9-bit character
	localparam logic [1:0] USY_FIFO_DEPTH = 2'h2; // receive fifo entries

	// link sequencer states
	typedef enum logic [1:0] {LK_IDLE, LK_TX, LK_RX} usy_link_e;

endpackage

// ---- logic/usy_baud_gen.sv ----
// baud tick generator for the master shift clock
`timescale 1ns/1ns
`default_nettype none

module usy_baud_gen
	import usy_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic wide,
	input wire logic [DIV_W-1:0] divisor,
	output logic tick
);

	// ==========================================================
	// down counter, one tick every reload+1 cycles
	logic [DIV_W-1:0] cnt_reg; // current count
	logic [DIV_W-1:0] cnt_next; // next count
	logic [DIV_W-1:0] reload; // value loaded at wrap

	// narrow mode only uses the low byte, so small divisors need no high write
	always_comb
	begin
		reload = wide ? divisor : {{(DIV_W-8){1'b0}}, divisor[7:0]};
		if (!run || cnt_reg == '0)
			cnt_next = reload;
		else
			cnt_next = cnt_reg - 1'b1;
	end

	// register only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	// held at reload while idle, so the first tick is a full period after start
	assign tick = run && (cnt_reg == '0);

endmodule

`default_nettype wire

// ---- bench/usy_far_dev.sv ----
// far-side model: a serial device facing the port's clock and data pins
`timescale 1ns/1ns
`default_nettype none

module usy_far_dev
(
	input wire logic pclk,
	input wire logic clk_line,
	input wire logic pol,
	input wire logic dt_line,
	input wire logic talk,
	input wire logic nine,
	input wire logic [8:0] tx_word,
	output logic dt_drive,
	output logic [8:0] rx_shift,
	output int rx_count
);
	// ==========================================================
	// edge tracking
	logic prev = 1'b0; // clock level one cycle ago, polarity removed
	logic [3:0] idx = 4'h0; // next bit to send
	logic lvl; // clock level, active high
	assign lvl = clk_line ^ pol;
	initial dt_drive = 1'b1;

	// link is far slower than pclk, so edges are seen by sampling
	always @(posedge pclk)
	begin
		prev <= lvl;
		if (!talk)
			idx <= 4'h0; // silent outside receive frames
		else if (lvl && !prev)
		begin
			// change at leading edge, lsb first, ninth last
			dt_drive <= tx_word[idx];
			idx <= (idx == (nine ? 4'h8 : 4'h7)) ? 4'h0 : idx + 4'h1;
		end
		if (!lvl && prev)
		begin
			// capture at trailing edge, newest bit at the top
			rx_shift <= {dt_line, rx_shift[8:1]};
			rx_count <= rx_count + 1;
		end
	end
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the clocked serial port
`timescale 1ns/1ns
`default_nettype none

module testbench
	import usy_pkg::*;
;
	// ==========================================================
	// signals
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, ck_val, ck_oe, dt_val, dt_oe, ck_line, dt_line, dt_drive;
	logic talk = 1'b0, nine = 1'b0, pol = 1'b0, ext_ck = 1'b0;
	logic [8:0] tx_word = 9'h000, rx_shift;
	int rx_count, base, mismatches = 0, tests_run = 0, cycles = 0;

	assign ck_line = ck_oe ? ck_val : (ext_ck ^ pol); // released: bench clock, idle level at rest
	assign dt_line = dt_oe ? dt_val : (talk ? dt_drive : 1'b1); // pull-up

	always #5 pclk = ~pclk;

	usy_sync_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clock_transmit_pin_sense(ck_line),
		.clock_transmit_pin_value(ck_val), .clock_transmit_pin_oe(ck_oe),
		.data_receive_pin_sense(dt_line), .data_receive_pin_value(dt_val),
		.data_receive_pin_oe(dt_oe));

	usy_far_dev far (.pclk(pclk), .clk_line(ck_line), .pol(pol), .dt_line(dt_line),
		.talk(talk), .nine(nine), .tx_word(tx_word), .dt_drive(dt_drive),
		.rx_shift(rx_shift), .rx_count(rx_count));

	// ==========================================================
	// shared tasks
	task stop_test;
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; an edge passes after release so calls may chain
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// wait for the far side to have seen n trailing edges
	task wait_cnt(input int n);
		for (int i = 0; i < 2000 && rx_count < n; i++)
			@(posedge pclk);
	endtask

	// ==========================================================
	// scenarios
	task t_reset;
		rdc(USY_OFF_TSC, 32'h2);
		rdc(USY_OFF_RSC, 32'h0);
		rdc(USY_OFF_BCN, 32'h0);
		rdc(USY_OFF_BDL, 32'h0);
		rdc(USY_OFF_BDH, 32'h0);
		rdc(USY_OFF_FLG, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk({30'h0, ck_oe, dt_oe}, 32'h0);
	endtask

	// two characters back to back, then one nine-bit with idle-high clock
	task t_tx;
		apb(1'b1, USY_OFF_BDL, 32'h1);
		apb(1'b1, USY_OFF_RSC, 32'h80);
		apb(1'b1, USY_OFF_TSC, 32'hb0);
		chk({30'h0, ck_oe, dt_oe}, 32'h3);
		base = rx_count;
		apb(1'b1, USY_OFF_THR, 32'ha5);
		apb(1'b1, USY_OFF_THR, 32'h3c);
		wait_cnt(base + 8);
		chk(rx_shift[8:1], 32'ha5);
		wait_cnt(base + 16);
		chk(rx_shift[8:1], 32'h3c);
		repeat (40) @(posedge pclk);
		chk(rx_count, base + 16);
		chk(ck_line, 32'h0);
		rdc(USY_OFF_FLG, 32'h1);
		pol <= 1'b1;
		apb(1'b1, USY_OFF_BCN, 32'h10);
		apb(1'b1, USY_OFF_TSC, 32'hf1);
		base = rx_count;
		apb(1'b1, USY_OFF_THR, 32'h3c);
		wait_cnt(base + 9);
		chk(rx_shift, 32'h13c);
		chk(ck_line, 32'h1);
		pol <= 1'b0;
		apb(1'b1, USY_OFF_BCN, 32'h0);
	endtask

	// one character on single receive
	task t_single;
		apb(1'b1, USY_OFF_TSC, 32'h90);
		tx_word <= 9'h05a;
		talk <= 1'b1;
		base = rx_count;
		apb(1'b1, USY_OFF_RSC, 32'ha0);
		wait_cnt(base + 3);
		chk({30'h0, ck_oe, dt_oe}, 32'h2);
		rd = 32'h0;
		for (int i = 0; i < 200 && rd[1] !== 1'b1; i++)
			apb(1'b0, USY_OFF_FLG, 32'h0);
		repeat (40) @(posedge pclk);
		chk(rx_count, base + 8);
		rdc(USY_OFF_RSC, 32'h80);
		rdc(USY_OFF_RDR, 32'h5a);
		rdc(USY_OFF_FLG, 32'h1);
	endtask

	// both receive bits, nine-bit characters, run into overrun
	task t_overrun;
		tx_word <= 9'h1a5;
		nine <= 1'b1;
		apb(1'b1, USY_OFF_RSC, 32'hf0);
		rd = 32'h0;
		for (int i = 0; i < 300 && rd[1] !== 1'b1; i++)
			apb(1'b0, USY_OFF_RSC, 32'h0);
		rdc(USY_OFF_RSC, 32'hd3);
		rdc(USY_OFF_RDR, 32'ha5);
		rdc(USY_OFF_RSC, 32'hd3);
		rdc(USY_OFF_RDR, 32'ha5);
		rdc(USY_OFF_FLG, 32'h1);
		apb(1'b1, USY_OFF_RSC, 32'hc0);
		rdc(USY_OFF_RSC, 32'hc0);
		talk <= 1'b0;
	endtask

	// bench acts as link master: exactly eight clock cycles, slow against pclk
	task ext_clk8;
		repeat (8)
		begin
			ext_ck <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_ck <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask

	// slave role: one character in, then one character out on the bench clock
	task t_slave;
		nine <= 1'b0;
		tx_word <= 9'h0c3;
		apb(1'b1, USY_OFF_TSC, 32'h10);
		talk <= 1'b1;
		apb(1'b1, USY_OFF_RSC, 32'h90);
		chk({30'h0, ck_oe, dt_oe}, 32'h0);
		ext_clk8();
		rdc(USY_OFF_RDR, 32'hc3);
		talk <= 1'b0;
		apb(1'b1, USY_OFF_RSC, 32'h80);
		apb(1'b1, USY_OFF_TSC, 32'h30);
		chk({30'h0, ck_oe, dt_oe}, 32'h1);
		apb(1'b1, USY_OFF_THR, 32'h96);
		ext_clk8();
		chk(rx_shift[8:1], 32'h96);
	endtask

	// ==========================================================
	// hang guard and main sequence
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			stop_test();
		end
	end

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_tx();
		t_single();
		t_overrun();
		t_slave();
		stop_test();
	end
endmodule

`default_nettype wire
